/* src/acp_params.svh */
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// operand stack geometry
`define ACP_STACK_BYTES   16
`define ACP_STACK_IDX_W   4

// pin vector layout after synchronisation
`define ACP_PIN_CS        5
`define ACP_PIN_CMDSEL    4
`define ACP_PIN_RD        3
`define ACP_PIN_WR        2
`define ACP_PIN_DACK      1
`define ACP_PIN_SACK      0
`define ACP_PIN_IDLE      6'h3f

// status register field positions
`define ACP_ST_BUSY       7
`define ACP_ST_SIGN       6
`define ACP_ST_ZERO       5
`define ACP_ST_ERR_HI     4
`define ACP_ST_ERR_LO     1
`define ACP_ST_CARRY      0

// error code values
`define ACP_ERR_NONE      4'h0
`define ACP_ERR_DIVZ      4'h8
`define ACP_ERR_NEGARG    4'h4
`define ACP_ERR_BIGARG    4'hc
`define ACP_ERR_UNDER     4'h2
`define ACP_ERR_OVER      4'h1

// command byte: service request flag and opcode field
`define ACP_SERVICE_REQUEST_BIT     7
`define ACP_OP_NOP        7'h00
`define ACP_OP_SADD       7'h6c
`define ACP_OP_SSUB       7'h6d
`define ACP_OP_SMUL       7'h6e
`define ACP_OP_CHSS       7'h74
`define ACP_OP_PTOS       7'h77
`define ACP_OP_POPS       7'h78
`define ACP_OP_XCHS       7'h79
`define ACP_OP_DADD       7'h2c
`define ACP_OP_DSUB       7'h2d
`define ACP_OP_CHSD       7'h34
`define ACP_OP_PTOD       7'h37
`define ACP_OP_POPD       7'h38

// fixed execution time of every command, in clk cycles
`define ACP_EXEC_CYCLES   6'h10

`endif

/* src/acp_pkg.sv */
package acp_pkg;

    // host access handshake states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_XFER = 2'b10,
        ST_HOLD = 2'b11
    } acp_state_e;

    // access kind, coded as {command_data_sel, read}
    typedef enum logic [1:0] {
        ACC_DATA_WR = 2'b00,
        ACC_DATA_RD = 2'b01,
        ACC_CMD_WR  = 2'b10,
        ACC_STAT_RD = 2'b11
    } acp_access_e;

    // floating point word: sign, 7-bit exponent, 24-bit fraction
    typedef struct packed {
        logic        sign;
        logic [6:0]  exponent;
        logic [23:0] mantissa;
    } acp_float_s;

endpackage

/* src/acp_byte_stack.sv */
`include "acp_params.svh"
// sixteen byte operand stack; entry 0 is top of stack
module acp_byte_stack (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        pushEn,
    input  wire logic [7:0]  pushByte,
    input  wire logic        popEn,
    input  wire logic        loadEn,
    input  wire logic [3:0]  loadRot,
    input  wire logic [2:0]  loadCnt,
    input  wire logic [31:0] loadData,
    output logic      [63:0] topBytes
);
    logic [7:0] mem [`ACP_STACK_BYTES];

    // one register per entry; push shifts down, pop rotates up
    for (genvar i = 0; i < `ACP_STACK_BYTES; i++) begin : g_entry
        logic [3:0] rotSrc;
        logic [3:0] popSrc;
        logic [7:0] loadByte;
        assign rotSrc = 4'(i) + loadRot;
        assign popSrc = 4'(i) + 4'h1;
        if (i < 4) begin : g_res
            assign loadByte = (3'(i) < loadCnt) ? loadData[31-8*i -: 8]
                                                : mem[rotSrc];
        end else begin : g_keep
            assign loadByte = mem[rotSrc];
        end
        always_ff @(posedge clk) begin
            if (!resetn) begin
                mem[i] <= 8'h00;
            end else if (pushEn) begin
                // bottom byte falls off the end
                mem[i] <= (i == 0) ? pushByte : mem[(i + 15) % 16];
            end else if (popEn) begin
                mem[i] <= mem[popSrc];
            end else if (loadEn) begin
                mem[i] <= loadByte;
            end
        end
        if (i < 8) begin : g_top
            assign topBytes[63-8*i -: 8] = mem[i];
        end
    end
endmodule

/* src/acp_host_port.sv */
`include "acp_params.svh"
// Overview of operation
// - fixed operands are two's complement, sign in the top bit
// - float word: sign on top, 7-bit exponent, 24-bit fraction
// - floats normalised with fraction bit 23 set; zero is all zeros
// - stack holds eight 16-bit levels, or four 32-bit values
// - stack takes a byte per write; reads return bytes in reverse
// - data write pushes a byte on top, bottom byte is lost
// - data read returns top byte, which rotates to the bottom
// - command write starts a command on top and next operands
// - on completion drop exec_done_n, clear busy, maybe raise request
// - done ack releases exec_done_n; service ack drops the request
// - command write while busy waits with ready low until done
// - stack access while busy waits with ready low until done
// - idle stack read: ready low only while top byte is latched
// - idle stack write: ready low until the latch is free
// - status read: ready low briefly, accepted even while busy
// - status: busy, sign, zero, four-bit error code, carry
// - sign and zero flags describe the top of stack value
// - error field codes divide, negative argument, range, under/over
// - carry flag shows carry or borrow out of the top bit
// - other status bits are undefined while busy reads one
// - status read puts the status register on the bus any time
module acp_host_port (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       chipSelectN,
    input  wire logic       commandDataSel,
    input  wire logic       readStrobeN,
    input  wire logic       writeStrobeN,
    input  wire logic [7:0] dataIn,
    output logic      [7:0] dataOut,
    output logic            dataOe,
    output logic            ready,
    output logic            execDoneN,
    output logic            serviceRequest,
    input  wire logic       doneAckN,
    input  wire logic       serviceAckN
);
    logic [5:0]               pinMeta_r;
    logic [5:0]               pinSync_r;
    logic [7:0]               dataMeta_r;
    logic [7:0]               dataSync_r;
    logic                     rdAct;
    logic                     wrAct;
    logic                     accReq;
    logic                     doneAck;
    logic                     service_ack_n;
    acp_pkg::acp_access_e     kindNow;
    acp_pkg::acp_access_e     kind_r;
    acp_pkg::acp_state_e      state_r;
    acp_pkg::acp_state_e      stateNxt;
    logic                     xfer;
    logic                     ready_r;
    logic [7:0]               dataOut_r;
    logic                     dataOe_r;
    logic                     execDoneN_r;
    logic                     serviceRequest_r;
    logic                     busy_r;
    logic [7:0]               cmd_r;
    logic [5:0]               cnt_r;
    logic                     finish;
    logic                     sign_r;
    logic                     zero_r;
    logic [3:0]               err_r;
    logic                     carry_r;
    logic [7:0]               statusVal;
    logic [63:0]              topBytes;
    logic [15:0]              au;
    logic [15:0]              al;
    logic [31:0]              a32;
    logic [31:0]              b32;
    logic [16:0]              sum17;
    logic [16:0]              dif17;
    logic [31:0]              prod32;
    logic [32:0]              sum33;
    logic [32:0]              dif33;
    logic [3:0]               loadRot;
    logic [2:0]               loadCnt;
    logic [31:0]              loadData;
    logic                     flagUpd;
    logic                     wide;
    logic [15:0]              top16;
    logic [31:0]              top32;
    logic                     resCarry;
    logic [3:0]               resErr;
    logic                     resSign;
    logic                     resZero;
    acp_pkg::acp_float_s      topFloat;

    // two flops on every host pin before anything looks at it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinMeta_r  <= `ACP_PIN_IDLE;
            pinSync_r  <= `ACP_PIN_IDLE;
            dataMeta_r <= 8'h00;
            dataSync_r <= 8'h00;
        end else begin
            pinMeta_r  <= {chipSelectN, commandDataSel, readStrobeN,
                           writeStrobeN, doneAckN, serviceAckN};
            pinSync_r  <= pinMeta_r;
            dataMeta_r <= dataIn;
            dataSync_r <= dataMeta_r;
        end
    end

    // decode; both strobes low at once is no access at all
    assign rdAct   = !pinSync_r[`ACP_PIN_RD];
    assign wrAct   = !pinSync_r[`ACP_PIN_WR];
    assign accReq  = !pinSync_r[`ACP_PIN_CS] && (rdAct != wrAct);
    assign doneAck = !pinSync_r[`ACP_PIN_DACK];
    assign service_ack_n   = !pinSync_r[`ACP_PIN_SACK];
    assign kindNow = acp_pkg::acp_access_e'({pinSync_r[`ACP_PIN_CMDSEL],
                                             rdAct});

    // access handshake: wait while busy, one latch cycle, then hold
    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            acp_pkg::ST_IDLE: begin
                if (accReq) begin
                    // status reads never wait on a command
                    if (busy_r && kindNow != acp_pkg::ACC_STAT_RD) begin
                        stateNxt = acp_pkg::ST_WAIT;
                    end else begin
                        stateNxt = acp_pkg::ST_XFER;
                    end
                end
            end
            acp_pkg::ST_WAIT: begin
                if (!busy_r) begin
                    stateNxt = acp_pkg::ST_XFER;
                end
            end
            acp_pkg::ST_XFER: begin
                stateNxt = acp_pkg::ST_HOLD;
            end
            acp_pkg::ST_HOLD: begin
                // lines are held steady by the host until ready rises
                if (!accReq) begin
                    stateNxt = acp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // state, access kind and ready line
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= acp_pkg::ST_IDLE;
            kind_r  <= acp_pkg::ACC_DATA_WR;
            ready_r <= 1'b1;
        end else begin
            state_r <= stateNxt;
            if (state_r == acp_pkg::ST_IDLE && accReq) begin
                kind_r <= kindNow;
            end
            ready_r <= (stateNxt == acp_pkg::ST_IDLE) ||
                       (stateNxt == acp_pkg::ST_HOLD);
        end
    end

    assign xfer = (state_r == acp_pkg::ST_XFER);

    // status byte, busy on top
    assign statusVal = {busy_r, sign_r, zero_r, err_r, carry_r};

    // read latch; driven until the host lets go of the strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dataOut_r <= 8'h00;
            dataOe_r  <= 1'b0;
        end else begin
            if (xfer && kind_r == acp_pkg::ACC_DATA_RD) begin
                dataOut_r <= topBytes[63:56];
            end else if (xfer && kind_r == acp_pkg::ACC_STAT_RD) begin
                dataOut_r <= statusVal;
            end
            dataOe_r <= (stateNxt == acp_pkg::ST_HOLD) &&
                        (kind_r == acp_pkg::ACC_DATA_RD ||
                         kind_r == acp_pkg::ACC_STAT_RD);
        end
    end

    // command execution: fixed length countdown
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            cmd_r  <= 8'h00;
            cnt_r  <= 6'h00;
        end else if (xfer && kind_r == acp_pkg::ACC_CMD_WR) begin
            busy_r <= 1'b1;
            cmd_r  <= dataSync_r;
            cnt_r  <= `ACP_EXEC_CYCLES;
        end else if (busy_r) begin
            cnt_r <= cnt_r - 6'h01;
            if (finish) begin
                busy_r <= 1'b0;
            end
        end
    end

    assign finish = busy_r && (cnt_r == 6'h01);

    // completion lines; a finish beats an ack in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            execDoneN_r      <= 1'b1;
            serviceRequest_r <= 1'b0;
        end else begin
            if (finish) begin
                execDoneN_r <= 1'b0;
            end else if (doneAck) begin
                execDoneN_r <= 1'b1;
            end
            if (finish && cmd_r[`ACP_SERVICE_REQUEST_BIT]) begin
                serviceRequest_r <= 1'b1;
            end else if (service_ack_n) begin
                serviceRequest_r <= 1'b0;
            end
        end
    end

    // operands: top 16-bit levels and top two 32-bit values
    assign au     = topBytes[63:48];
    assign al     = topBytes[47:32];
    assign a32    = topBytes[63:32];
    assign b32    = topBytes[31:0];
    assign sum17  = {1'b0, al} + {1'b0, au};
    assign dif17  = {1'b0, al} - {1'b0, au};
    assign prod32 = $signed(al) * $signed(au);
    assign sum33  = {1'b0, b32} + {1'b0, a32};
    assign dif33  = {1'b0, b32} - {1'b0, a32};

    // result, stack rearrangement and flags for each opcode
    always_comb begin
        loadRot  = 4'h0;
        loadCnt  = 3'h0;
        loadData = 32'h0;
        flagUpd  = 1'b1;
        wide     = 1'b0;
        top16    = 16'h0;
        top32    = 32'h0;
        resCarry = 1'b0;
        resErr   = `ACP_ERR_NONE;
        case (cmd_r[6:0])
            `ACP_OP_SADD: begin
                loadRot = 4'h2;
                top16   = sum17[15:0];
                resCarry = sum17[16];
                if (al[15] == au[15] && top16[15] != al[15]) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_SSUB: begin
                loadRot = 4'h2;
                top16   = dif17[15:0];
                resCarry = dif17[16];
                if (al[15] != au[15] && top16[15] != al[15]) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_SMUL: begin
                loadRot = 4'h2;
                top16   = prod32[15:0];
                if (prod32[31:16] != {16{prod32[15]}}) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_CHSS: begin
                top16 = 16'h0000 - au;
                if (au == 16'h8000) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_PTOS: begin
                loadRot = 4'he;
                top16   = au;
            end
            `ACP_OP_POPS: begin
                loadRot = 4'h2;
                top16   = al;
            end
            `ACP_OP_XCHS: begin
                top16 = al;
            end
            `ACP_OP_DADD: begin
                wide     = 1'b1;
                loadRot  = 4'h4;
                top32    = sum33[31:0];
                resCarry = sum33[32];
                if (b32[31] == a32[31] && top32[31] != b32[31]) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_DSUB: begin
                wide     = 1'b1;
                loadRot  = 4'h4;
                top32    = dif33[31:0];
                resCarry = dif33[32];
                if (b32[31] != a32[31] && top32[31] != b32[31]) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_CHSD: begin
                wide  = 1'b1;
                top32 = 32'h0000_0000 - a32;
                if (a32 == 32'h8000_0000) begin
                    resErr = `ACP_ERR_OVER;
                end
            end
            `ACP_OP_PTOD: begin
                wide    = 1'b1;
                loadRot = 4'hc;
                top32   = a32;
            end
            `ACP_OP_POPD: begin
                wide    = 1'b1;
                loadRot = 4'h4;
                top32   = b32;
            end
            default: begin
                // no-op and unknown opcodes leave stack and flags alone
                flagUpd = 1'b0;
            end
        endcase
        // pops leave no result; xchs rewrites both halves
        if (!flagUpd || cmd_r[6:0] == `ACP_OP_POPS ||
            cmd_r[6:0] == `ACP_OP_POPD) begin
            loadCnt = 3'h0;
        end else if (cmd_r[6:0] == `ACP_OP_XCHS) begin
            loadCnt  = 3'h4;
            loadData = {al, au};
        end else if (wide) begin
            loadCnt  = 3'h4;
            loadData = top32;
        end else begin
            loadCnt  = 3'h2;
            loadData = {top16, 16'h0000};
        end
    end

    // flags from the new top; a 32-bit top reads as sign/exp/fraction
    assign topFloat = acp_pkg::acp_float_s'(top32);
    assign resSign  = wide ? topFloat.sign : top16[15];
    assign resZero  = wide ? (top32 == 32'h0) : (top16 == 16'h0);

    // flags are only rewritten at completion, so they hold old values
    // while busy and software must not trust them then
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sign_r  <= 1'b0;
            zero_r  <= 1'b0;
            err_r   <= `ACP_ERR_NONE;
            carry_r <= 1'b0;
        end else if (finish && flagUpd) begin
            sign_r  <= resSign;
            zero_r  <= resZero;
            err_r   <= resErr;
            carry_r <= resCarry;
        end
    end

    // stack is shared: host bytes when idle, results at completion
    acp_byte_stack u_stack (
        .clk      (clk),
        .resetn   (resetn),
        .pushEn   (xfer && kind_r == acp_pkg::ACC_DATA_WR),
        .pushByte (dataSync_r),
        .popEn    (xfer && kind_r == acp_pkg::ACC_DATA_RD),
        .loadEn   (finish && flagUpd),
        .loadRot  (loadRot),
        .loadCnt  (loadCnt),
        .loadData (loadData),
        .topBytes (topBytes)
    );

    assign dataOut        = dataOut_r;
    assign dataOe         = dataOe_r;
    assign ready          = ready_r;
    assign execDoneN      = execDoneN_r;
    assign serviceRequest = serviceRequest_r;
endmodule

/* tb/acp_host_port_assertions.sv */
// watches the host-side pins of the coprocessor port
module acp_host_port_assertions (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       chipSelectN,
    input wire logic       commandDataSel,
    input wire logic       readStrobeN,
    input wire logic       writeStrobeN,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic       dataOe,
    input wire logic       ready,
    input wire logic       execDoneN,
    input wire logic       serviceRequest,
    input wire logic       doneAckN,
    input wire logic       serviceAckN
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking

    property p_rst;
        !resetn |=> ready && execDoneN && !serviceRequest && !dataOe;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_doneAck;
        disable iff (!resetn) (!doneAckN) [*3] |-> ##2 execDoneN;
    endproperty
    a_doneAck: assert property (p_doneAck) else $error("done not released");
    property p_svcAck;
        disable iff (!resetn) (!serviceAckN) [*3] |-> ##2 !serviceRequest;
    endproperty
    a_svcAck: assert property (p_svcAck) else $error("request not dropped");
    // with four ack-free samples no ack is left in the synchroniser, so a pending done must stay low
    property p_doneHold;
        disable iff (!resetn) !execDoneN && doneAckN && $past(doneAckN)
            && $past(doneAckN, 2) && $past(doneAckN, 3) |=> !execDoneN;
    endproperty
    a_doneHold: assert property (p_doneHold) else $error("done dropped");
    property p_svcSet;
        disable iff (!resetn) $rose(serviceRequest) |-> !execDoneN;
    endproperty
    a_svcSet: assert property (p_svcSet) else $error("request w/o done");
    property p_statQuick;
        disable iff (!resetn)
            $fell(ready) && commandDataSel && !readStrobeN |-> ##[1:3] ready;
    endproperty
    a_statQuick: assert property (p_statQuick) else $error("slow status");
    property p_waitBound;
        disable iff (!resetn) $fell(ready) |-> ##[1:24] ready;
    endproperty
    a_waitBound: assert property (p_waitBound) else $error("ready stuck");
    property p_oeRise;
        disable iff (!resetn)
            $rose(dataOe) |-> $rose(ready) && !readStrobeN && !chipSelectN;
    endproperty
    a_oeRise: assert property (p_oeRise) else $error("bad bus drive");
    property p_noOeWait;
        disable iff (!resetn) !ready |-> !dataOe;
    endproperty
    a_noOeWait: assert property (p_noOeWait) else $error("drive in wait");
endmodule

bind acp_host_port acp_host_port_assertions u_chk (.clk, .resetn,
    .chipSelectN, .commandDataSel, .readStrobeN, .writeStrobeN, .dataIn,
    .dataOut, .dataOe, .ready, .execDoneN, .serviceRequest, .doneAckN,
    .serviceAckN);

/* tb/acp_host_model.sv */
// host processor on the 8-bit bus
module acp_host_model (
    input  wire logic       clk,
    input  wire logic       ready,
    input  wire logic [7:0] dataOut,
    output logic            chipSelectN,
    output logic            commandDataSel,
    output logic            readStrobeN,
    output logic            writeStrobeN,
    output logic      [7:0] dataIn,
    output logic            doneAckN,
    output logic            serviceAckN
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chipSelectN = 1'b1;
        commandDataSel = 1'b0;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        dataIn = 8'h5a;
        doneAckN = 1'b1;
        serviceAckN = 1'b1;
    end

    // one bus cycle; lines stay put until ready is sampled high again
    task automatic access(input logic sel, input logic rd,
                          input logic [7:0] wb, output logic [7:0] rb,
                          output int waited);
        waited = 0;
        @(negedge clk);
        chipSelectN = 1'b0;
        commandDataSel = sel;
        readStrobeN = ~rd;
        writeStrobeN = rd;
        dataIn = rd ? ~dataIn : wb;
        while (ready === 1'b1 && waited < 8) begin
            @(posedge clk);
            waited++;
        end
        while (ready !== 1'b1 && waited < 200) begin
            @(posedge clk);
            waited++;
        end
        rb = dataOut;
        @(negedge clk);
        chipSelectN = 1'b1;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        dataIn = ~dataIn; // released bus shows no stale byte
        repeat (4) @(negedge clk);
    endtask

    // three-cycle low pulse on one acknowledge line
    task automatic ack(input logic svc);
        @(negedge clk);
        if (svc) serviceAckN = 1'b0;
        else doneAckN = 1'b0;
        repeat (3) @(negedge clk);
        serviceAckN = 1'b1;
        doneAckN = 1'b1;
        repeat (3) @(negedge clk);
    endtask
endmodule

/* tb/acp_host_port_tb.sv */
`include "acp_params.svh"
module acp_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       resetn;
    logic       chipSelectN, commandDataSel, readStrobeN, writeStrobeN;
    logic [7:0] dataIn, dataOut;
    logic       dataOe, ready, execDoneN, serviceRequest;
    logic       doneAckN, serviceAckN;
    int         mismatches, testsRun;

    acp_host_port u_dut (.clk, .resetn, .chipSelectN, .commandDataSel,
        .readStrobeN, .writeStrobeN, .dataIn, .dataOut, .dataOe, .ready,
        .execDoneN, .serviceRequest, .doneAckN, .serviceAckN);
    acp_host_model u_host (.clk, .ready, .dataOut, .chipSelectN,
        .commandDataSel, .readStrobeN, .writeStrobeN, .dataIn, .doneAckN,
        .serviceAckN);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        testsRun++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reset;
        logic [7:0] rb;
        int         w;
        chk("idle pins", 8'h0c, 8'({ready, execDoneN, serviceRequest, dataOe}));
        u_host.access(1'b1, 1'b1, 8'h00, rb, w);
        chk("status", 8'h00, rb);
        chk("status wait", 8'h1, 8'(w <= 6));
    endtask

    // seventeen pushes overrun sixteen bytes; the seventeenth pop wraps
    task automatic t_rotate;
        logic [7:0] rb;
        int         w;
        for (int i = 1; i <= 17; i++) begin
            u_host.access(1'b0, 1'b0, 8'(i), rb, w);
            chk("push wait", 8'h1, 8'(w <= 6));
        end
        for (int k = 0; k <= 16; k++) begin
            u_host.access(1'b0, 1'b1, 8'h00, rb, w);
            chk("pop", 8'(k < 16 ? 17 - k : 17), rb);
            chk("pop wait", 8'h1, 8'(w <= 6));
        end
    endtask

    task automatic t_cmd(input logic [7:0] op, input logic [15:0] lo,
                         input logic [15:0] hi, input logic [15:0] res,
                         input logic [7:0] st);
        logic [7:0]  rb;
        logic [31:0] v;
        int          w;
        v = {hi, lo};
        for (int j = 0; j < 4; j++) begin
            u_host.access(1'b0, 1'b0, v[8*j +: 8], rb, w);
        end
        u_host.access(1'b1, 1'b0, op, rb, w);
        chk("cmd wait", 8'h1, 8'(w <= 6));
        u_host.access(1'b0, 1'b1, 8'h00, rb, w);
        chk("busy pop wait", 8'h1, 8'(w >= 8));
        chk("result hi", res[15:8], rb);
        u_host.access(1'b0, 1'b1, 8'h00, rb, w);
        chk("result lo", res[7:0], rb);
        u_host.access(1'b1, 1'b1, 8'h00, rb, w);
        chk("status", st, rb);
        chk("done pins", 8'(op[7]), 8'({execDoneN, serviceRequest}));
        u_host.ack(1'b0);
        chk("done ack", 8'h1, 8'(execDoneN));
        u_host.ack(1'b1);
        chk("request ack", 8'h0, 8'(serviceRequest));
    endtask

    // a command queued behind a busy unit, then a reset with done pending
    task automatic t_busy;
        logic [7:0] rb;
        int         w;
        u_host.access(1'b1, 1'b0, 8'h00, rb, w);
        u_host.access(1'b1, 1'b1, 8'h00, rb, w);
        chk("busy bit", 8'h1, 8'(rb[7]));
        chk("status wait", 8'h1, 8'(w <= 6));
        u_host.access(1'b1, 1'b0, 8'h00, rb, w);
        u_host.access(1'b1, 1'b0, 8'h00, rb, w);
        chk("queued cmd wait", 8'h1, 8'(w >= 8));
        repeat (30) @(negedge clk);
        u_host.access(1'b1, 1'b1, 8'h00, rb, w);
        chk("nop status", 8'h41, rb);
        chk("no request", 8'h0, 8'(serviceRequest));
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        chk("idle pins", 8'h0c, 8'({ready, execDoneN, serviceRequest, dataOe}));
    endtask

    // a hang cuts the run short through the same closing task
    initial begin
        repeat (8000) @(posedge clk);
        mismatches++;
        $display("MISMATCH watchdog expected end seen timeout");
        test_done();
    end

    initial begin
        resetn = 1'b0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_rotate();
        t_cmd({1'b1, `ACP_OP_SADD}, 16'h1234, 16'h7000, 16'h8234, 8'h42);
        t_cmd({1'b0, `ACP_OP_SSUB}, 16'h0005, 16'h0005, 16'h0000, 8'h20);
        t_cmd({1'b0, `ACP_OP_SSUB}, 16'h0003, 16'h0005, 16'hfffe, 8'h41);
        t_cmd({1'b0, `ACP_OP_SMUL}, 16'h0003, 16'hfffc, 16'hfff4,
              8'h40);
        t_cmd({1'b1, `ACP_OP_CHSS}, 16'h0000, 16'h8000, 16'h8000,
              8'h42);
        t_cmd({1'b0, `ACP_OP_XCHS}, 16'h9000, 16'h0001, 16'h9000,
              8'h40);
        t_cmd({1'b0, `ACP_OP_POPS}, 16'h00a5, 16'h5a5a, 16'h00a5,
              8'h00);
        t_cmd({1'b0, `ACP_OP_PTOS}, 16'h1111, 16'h8000, 16'h8000,
              8'h40);
        t_cmd({1'b0, `ACP_OP_CHSD}, 16'h0001, 16'h0000, 16'hffff,
              8'h40);
        // a 32-bit one is not zero even with a zero upper half
        t_cmd({1'b0, `ACP_OP_PTOD}, 16'h0001, 16'h0000, 16'h0000,
              8'h00);
        // next on stack is the copy left by ptod, two bytes rotated
        t_cmd({1'b0, `ACP_OP_DSUB}, 16'h0000, 16'h0002, 16'hffff,
              8'h41);
        t_busy();
        test_done();
    end
endmodule
